// >>> logic/fdr_drive_decode.sv
`timescale 1ns/1ps

module fdr_drive_decode
    import fdr_pkg::*;
#(
    parameter int NUM_DRIVES = 3
) (
    input wire logic [1:0] drive_pick, // Encoded drive number, two bits.
    input wire logic [NUM_DRIVES-1:0] motor_on, // Motor enables, active high.
    output logic [NUM_DRIVES-1:0] drive_sel_n, // Drive selects, active low.
    output logic [NUM_DRIVES-1:0] motor_on_n // Motor pins, active low.
);

    // ------------------------------------------------------------
    // Per-drive select and motor pins
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < NUM_DRIVES; i++) begin : g_drive
            assign motor_on_n[i] = !motor_on[i];
            assign drive_sel_n[i] = !((drive_pick == 2'(i)) && (drive_pick != FDR_NO_DRIVE)
                && motor_on[i]);
        end
    endgenerate

endmodule : fdr_drive_decode

// >>> logic/fdr_drive_regs.sv
`timescale 1ns/1ps

// Notes on behaviour
// - write strobe with address 010 loads register
// - drive control register has no read path
// - bits 1:0 pick drive 0, 1, 2
// - select asserts only with matching motor on
// - third drive outputs exist in both modes
// - bit 2 low holds core in reset
// - legacy mode bit 3 gates DMA, IRQ, ack
// - enhanced mode gate is always enabled
// - bits 4-6 drive inverted motor pins
// - bit 7 unused, no fourth motor
// - reset clears bits 0 through 6
// - address 111 read returns input register
// - enhanced reads live density and change pins
// - enhanced reserved input bits read one
// - bit 0 mirrored as status drive select in enhanced mode, held low in legacy mode
module fdr_drive_regs
    import fdr_pkg::*;
(
    input wire logic clock, // System clock, 200 MHz.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic enhanced_mode, // 1 enhanced host mode, 0 legacy host mode.
    input wire logic cs_n, // Chip select, active low.
    input wire logic [2:0] addr, // Register address lines.
    input wire logic wr_n, // Write strobe, active low.
    input wire logic rd_n, // Read strobe, active low.
    input wire logic [7:0] data_in, // Host data bus, input side.
    output logic [7:0] data_out, // Host data bus, output side.
    output logic data_oe_n, // Data bus output enable, low while driving.
    input wire logic high_density_n, // High-density select state, active low.
    input wire logic disk_change, // Disk change pin level.
    output logic drive_sel_0_n, // Drive 0 select, active low.
    output logic drive_sel_1_n, // Drive 1 select, active low.
    output logic drive_sel_2_n, // Drive 2 select, active low.
    output logic motor_on_0_n, // Drive 0 motor enable, active low.
    output logic motor_on_1_n, // Drive 1 motor enable, active low.
    output logic motor_on_2_n, // Drive 2 motor enable, active low.
    output logic soft_reset_n, // Controller core reset, active low.
    output logic dma_irq_gate, // Effective DMA and interrupt gate.
    output logic status_drive_sel, // Drive select status bit for status B.
    input wire logic core_dma_req, // DMA request from the controller core.
    input wire logic core_irq, // Interrupt request from the controller core.
    input wire logic dma_ack_n, // DMA acknowledge pin, active low.
    output logic dma_req, // Gated DMA request pin.
    output logic irq, // Gated interrupt request pin.
    output logic core_dma_ack_n // Gated DMA acknowledge to the core, active low.
);

    // ------------------------------------------------------------
    // Host access decode
    // ------------------------------------------------------------
    logic [FDR_CTRL_W-1:0] drive_control_reg_ff;
    logic [FDR_CTRL_W-1:0] nxt_drive_control_reg;
    logic ctrl_write;
    logic input_read;
    logic [1:0] drive_pick;
    logic drive_pick_bit_lo;
    logic drive_pick_bit_hi;
    logic [FDR_NUM_DRIVES-1:0] motor_on;
    logic [FDR_NUM_DRIVES-1:0] sel_n_vec;
    logic [FDR_NUM_DRIVES-1:0] motor_n_vec;
    logic [5:0] input_rsvd;

    assign ctrl_write = fdr_hit(cs_n, addr, FDR_DRIVE_CTRL_ADDR) && !wr_n;

    assign input_read = fdr_hit(cs_n, addr, FDR_DRIVE_INPUT_ADDR) && !rd_n;

    // ------------------------------------------------------------
    // Drive control register
    // ------------------------------------------------------------
    // Bit 7 of the host byte is dropped here; nothing downstream of this
    // register can ever see it, so there is no fourth motor pin to drive.
    always_comb begin
        nxt_drive_control_reg = drive_control_reg_ff;
        if (ctrl_write) begin
            nxt_drive_control_reg = data_in[FDR_CTRL_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            drive_control_reg_ff <= FDR_CTRL_RESET;
        end else begin
            drive_control_reg_ff <= nxt_drive_control_reg;
        end
    end

    assign drive_pick_bit_lo = drive_control_reg_ff[FDR_PICK_LO_BIT];
    assign drive_pick_bit_hi = drive_control_reg_ff[FDR_PICK_HI_BIT];
    assign drive_pick = {drive_pick_bit_hi, drive_pick_bit_lo};
    assign motor_on = drive_control_reg_ff[FDR_MOTOR_LSB +: FDR_NUM_DRIVES];

    // ------------------------------------------------------------
    // Drive interface pins
    // ------------------------------------------------------------
    // three drives in every mode
    fdr_drive_decode #(
        .NUM_DRIVES(FDR_NUM_DRIVES)
    ) u_decode (
        .drive_pick(drive_pick),
        .motor_on(motor_on),
        .drive_sel_n(sel_n_vec),
        .motor_on_n(motor_n_vec)
    );

    assign drive_sel_0_n = sel_n_vec[0];
    assign drive_sel_1_n = sel_n_vec[1];
    assign drive_sel_2_n = sel_n_vec[2];
    assign motor_on_0_n = motor_n_vec[0];
    assign motor_on_1_n = motor_n_vec[1];
    assign motor_on_2_n = motor_n_vec[2];

    // ------------------------------------------------------------
    // Core control and DMA/interrupt gating
    // ------------------------------------------------------------
    // soft reset to core
    assign soft_reset_n = drive_control_reg_ff[FDR_SOFT_RST_BIT];

    assign dma_irq_gate = enhanced_mode || drive_control_reg_ff[FDR_GATE_BIT];

    // The acknowledge is gated as well, so a stray acknowledge while the
    // channel is disabled cannot start a transfer inside the core.
    assign dma_req = core_dma_req && dma_irq_gate;
    assign irq = core_irq && dma_irq_gate;
    assign core_dma_ack_n = dma_ack_n || !dma_irq_gate;

    assign status_drive_sel = enhanced_mode && drive_pick_bit_lo;

    // ------------------------------------------------------------
    // Drive input register read path
    // ------------------------------------------------------------
    // The input register is read straight from the pins with no sampling,
    // so the host sees the level present during the read strobe.
    // reserved bits per mode
    assign input_rsvd = enhanced_mode ? FDR_INPUT_RSVD_ENH : FDR_INPUT_RSVD_LEG;

    always_comb begin
        data_out = FDR_IDLE_DATA;
        data_oe_n = 1'b1;
        if (input_read) begin
            data_out = {disk_change, input_rsvd, high_density_n};
            data_oe_n = 1'b0;
            if (!enhanced_mode) begin
                data_out[FDR_DENSITY_BIT] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_write_latch: assert property (
        @(posedge clock) disable iff (!rst_n)
        ctrl_write |=> (drive_control_reg_ff == $past(data_in[6:0]))
    ) else $error("Drive control write was not latched.");

    chk_ctrl_hold: assert property (
        @(posedge clock) disable iff (!rst_n)
        !ctrl_write |=> $stable(drive_control_reg_ff)
    ) else $error("Drive control changed without a write.");

    chk_ctrl_no_read: assert property (
        @(posedge clock) disable iff (!rst_n)
        (!cs_n && addr == FDR_DRIVE_CTRL_ADDR) |-> data_oe_n
    ) else $error("Data bus driven on control register address.");

    chk_pick_drive_one: assert property (
        @(posedge clock) disable iff (!rst_n)
        (ctrl_write && data_in[1:0] == 2'h1 && data_in[5])
            |=> (!drive_sel_1_n && drive_sel_0_n && drive_sel_2_n)
    ) else $error("Drive number one did not select drive one.");

    chk_sel_needs_motor: assert property (
        @(posedge clock) disable iff (!rst_n)
        (ctrl_write && data_in[1:0] == 2'h0 && !data_in[4]) |=> drive_sel_0_n
    ) else $error("Drive 0 selected with its motor off.");

    chk_third_drive: assert property (
        @(posedge clock) disable iff (!rst_n)
        (ctrl_write && data_in[1:0] == 2'h2 && data_in[6])
            |=> (!drive_sel_2_n && !motor_on_2_n)
    ) else $error("Third drive select or motor missing.");

    chk_soft_reset: assert property (
        @(posedge clock) disable iff (!rst_n)
        (ctrl_write && !data_in[FDR_SOFT_RST_BIT]) |=> !soft_reset_n
    ) else $error("Core not held in reset by bit 2.");

    chk_soft_release: assert property (
        @(posedge clock) disable iff (!rst_n)
        (ctrl_write && data_in[FDR_SOFT_RST_BIT]) |=> soft_reset_n
    ) else $error("Core left in reset although bit 2 was written high.");

    chk_legacy_gate: assert property (
        @(posedge clock) disable iff (!rst_n)
        (!enhanced_mode && !drive_control_reg_ff[3]) |-> (!dma_req && !irq && core_dma_ack_n)
    ) else $error("Legacy mode passed DMA or interrupt while gated.");

    chk_enhanced_gate: assert property (
        @(posedge clock) disable iff (!rst_n)
        (enhanced_mode && core_irq && core_dma_req) |-> (irq && dma_req && dma_irq_gate)
    ) else $error("Enhanced mode blocked DMA or interrupt.");

    chk_motor_pins: assert property (
        @(posedge clock) disable iff (!rst_n)
        ctrl_write |=> ({motor_on_2_n, motor_on_1_n, motor_on_0_n} == ~$past(data_in[6:4]))
    ) else $error("Motor pins do not follow written bits.");

    chk_reset_clear: assert property (
        @(posedge clock) disable iff (!rst_n)
        $rose(rst_n) |-> (motor_on_0_n && motor_on_1_n && motor_on_2_n
            && !soft_reset_n && drive_sel_0_n)
    ) else $error("Reset did not clear drive control.");

    chk_input_read: assert property (
        @(posedge clock) disable iff (!rst_n)
        (!cs_n && addr == FDR_DRIVE_INPUT_ADDR && !rd_n) |-> !data_oe_n
            ##1 $stable(drive_control_reg_ff) || $past(ctrl_write)
    ) else $error("Input register read not driven.");

    chk_enh_read: assert property (
        @(posedge clock) disable iff (!rst_n)
        (input_read && enhanced_mode) |->
            (data_out[7] == disk_change && data_out[0] == high_density_n)
    ) else $error("Enhanced read lost live pin levels.");

    chk_rsvd_ones: assert property (
        @(posedge clock) disable iff (!rst_n)
        (input_read && enhanced_mode) |-> (data_out[6:1] == 6'h3F)
    ) else $error("Reserved input bits not one.");

    chk_status_mirror: assert property (
        @(posedge clock) disable iff (!rst_n)
        (ctrl_write && enhanced_mode) ##1 enhanced_mode |-> (status_drive_sel == $past(data_in[0]))
    ) else $error("Status drive select does not mirror bit 0.");

    chk_no_drive: assert property (
        @(posedge clock) disable iff (!rst_n)
        (ctrl_write && data_in[1:0] == 2'h3)
            |=> (drive_sel_0_n && drive_sel_1_n && drive_sel_2_n)
    ) else $error("Drive number three selected a drive.");

    chk_sel_motor_pair: assert property (
        @(posedge clock) disable iff (!rst_n)
        (drive_sel_0_n || !motor_on_0_n) && (drive_sel_1_n || !motor_on_1_n)
            && (drive_sel_2_n || !motor_on_2_n)
    ) else $error("A drive is selected while its motor is off.");

    chk_sel_onehot: assert property (
        @(posedge clock) disable iff (!rst_n)
        $onehot0(~{drive_sel_2_n, drive_sel_1_n, drive_sel_0_n})
    ) else $error("More than one drive selected.");

    chk_sel_matches_pick: assert property (
        @(posedge clock) disable iff (!rst_n)
        (drive_sel_0_n || drive_pick == 2'h0) && (drive_sel_1_n || drive_pick == 2'h1)
            && (drive_sel_2_n || drive_pick == 2'h2)
    ) else $error("Selected drive differs from the drive number.");

    chk_reset_value: assert property (
        @(posedge clock) disable iff (!rst_n)
        $rose(rst_n) |-> (drive_control_reg_ff == FDR_CTRL_RESET
            && (enhanced_mode || !dma_irq_gate))
    ) else $error("Drive control not cleared by reset.");

    chk_motor_live: assert property (
        @(posedge clock) disable iff (!rst_n)
        {motor_on_2_n, motor_on_1_n, motor_on_0_n}
            == ~drive_control_reg_ff[FDR_MOTOR_LSB +: FDR_NUM_DRIVES]
    ) else $error("Motor pins differ from the stored motor bits.");

    chk_legacy_pass: assert property (
        @(posedge clock) disable iff (!rst_n)
        (!enhanced_mode && drive_control_reg_ff[FDR_GATE_BIT])
            |-> (dma_req == core_dma_req && irq == core_irq && core_dma_ack_n == dma_ack_n)
    ) else $error("Legacy mode blocked DMA or interrupt with the gate open.");

    chk_enhanced_pass: assert property (
        @(posedge clock) disable iff (!rst_n)
        enhanced_mode
            |-> (dma_req == core_dma_req && irq == core_irq && core_dma_ack_n == dma_ack_n)
    ) else $error("Enhanced mode altered DMA, interrupt or acknowledge.");

    chk_legacy_read: assert property (
        @(posedge clock) disable iff (!rst_n)
        (input_read && !enhanced_mode) |-> (data_out == {disk_change, 7'h00})
    ) else $error("Legacy input register read returned wrong bits.");

    chk_idle_bus: assert property (
        @(posedge clock) disable iff (!rst_n)
        !input_read |-> (data_oe_n && data_out == FDR_IDLE_DATA)
    ) else $error("Data bus driven without an input register read.");

    chk_status_legacy: assert property (
        @(posedge clock) disable iff (!rst_n)
        !enhanced_mode |-> !status_drive_sel
    ) else $error("Status drive select set in legacy mode.");

endmodule : fdr_drive_regs

// >>> logic/fdr_pkg.sv
package fdr_pkg;

    // ------------------------------------------------------------
    // Host bus geometry and register addresses
    // ------------------------------------------------------------
    localparam int FDR_ADDR_W = 3;
    localparam int FDR_DATA_W = 8;
    localparam logic [2:0] FDR_DRIVE_CTRL_ADDR = 3'h2;
    localparam logic [2:0] FDR_DRIVE_INPUT_ADDR = 3'h7;

    // ------------------------------------------------------------
    // Drive control register fields
    // ------------------------------------------------------------
    localparam int FDR_CTRL_W = 7;
    localparam int FDR_PICK_LO_BIT = 0;
    localparam int FDR_PICK_HI_BIT = 1;
    localparam int FDR_SOFT_RST_BIT = 2;
    localparam int FDR_GATE_BIT = 3;
    localparam int FDR_MOTOR_LSB = 4;
    localparam int FDR_NUM_DRIVES = 3;
    localparam logic [6:0] FDR_CTRL_RESET = 7'h00;
    localparam logic [1:0] FDR_NO_DRIVE = 2'h3;

    // ------------------------------------------------------------
    // Drive input register fields
    // ------------------------------------------------------------
    localparam int FDR_DENSITY_BIT = 0;
    localparam int FDR_CHANGE_BIT = 7;
    localparam logic [5:0] FDR_INPUT_RSVD_ENH = 6'h3F;
    localparam logic [5:0] FDR_INPUT_RSVD_LEG = 6'h00;
    localparam logic [7:0] FDR_IDLE_DATA = 8'h00;

    // True when a host access with chip select low targets the given address.
    function automatic logic fdr_hit(
        input logic cs_n,
        input logic [2:0] addr,
        input logic [2:0] target
    );
        fdr_hit = !cs_n && (addr == target);
    endfunction : fdr_hit

endpackage : fdr_pkg

// >>> tb/fdr_drive_model.sv
`timescale 1ns/1ps

module fdr_drive_model (
    input wire logic [2:0] drive_sel_n, // Drive selects from the controller, active low.
    input wire logic [2:0] media_change, // Per-drive disk change flags.
    input wire logic media_hd, // Loaded media is high density.
    output logic disk_change, // Change line of the selected drive.
    output logic high_density_n // Density select line, active low.
);
    // An unselected drive releases its change line, and the line then rests low.
    assign disk_change = |(~drive_sel_n & media_change);
    assign high_density_n = ~media_hd;
endmodule : fdr_drive_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps

module tb_top import fdr_pkg::*;;
    logic clock = 0, rst_n = 0, enhanced_mode = 0, cs_n = 1, wr_n = 1, rd_n = 1;
    logic [2:0] addr = 3'h0, media_change = 3'h0;
    logic [7:0] data_in = 8'h00, data_out, rd_val, r;
    logic data_oe_n, high_density_n, disk_change, media_hd = 0, oe;
    logic soft_reset_n, dma_irq_gate, status_drive_sel, dma_req, irq, core_dma_ack_n;
    logic core_dma_req = 1, core_irq = 1, dma_ack_n = 0;
    wire [2:0] sel_n, mot_n;
    int err_count = 0, check_count = 0;

    always #2.5 clock = ~clock;

    fdr_drive_regs DUT (.clock(clock), .rst_n(rst_n), .enhanced_mode(enhanced_mode),
        .cs_n(cs_n), .addr(addr), .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .high_density_n(high_density_n),
        .disk_change(disk_change), .drive_sel_0_n(sel_n[0]), .drive_sel_1_n(sel_n[1]),
        .drive_sel_2_n(sel_n[2]), .motor_on_0_n(mot_n[0]), .motor_on_1_n(mot_n[1]),
        .motor_on_2_n(mot_n[2]), .soft_reset_n(soft_reset_n), .dma_irq_gate(dma_irq_gate),
        .status_drive_sel(status_drive_sel), .core_dma_req(core_dma_req),
        .core_irq(core_irq), .dma_ack_n(dma_ack_n), .dma_req(dma_req), .irq(irq),
        .core_dma_ack_n(core_dma_ack_n));

    fdr_drive_model drives (.drive_sel_n(sel_n), .media_change(media_change),
        .media_hd(media_hd), .disk_change(disk_change), .high_density_n(high_density_n));

    // ------------------------------------------------------------
    // Expected values and comparisons
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_pins(input logic [7:0] v, input logic enh);
        logic [2:0] s;
        s = 3'b111;
        if (v[1:0] != 2'h3 && v[4 + v[1:0]]) s[v[1:0]] = 1'b0;
        return {s, ~v[6:4], v[2], enh | v[3]};
    endfunction : exp_pins

    // Core requests are held high and the acknowledge pin low, so only the gate shows.
    function automatic logic [7:0] exp_side(input logic [7:0] v, input logic enh);
        logic g;
        g = enh | v[3];
        return {4'h0, g, g, ~g, enh & v[0]};
    endfunction : exp_side

    task automatic compare(input string what, input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s t=%0t got=%h exp=%h", what, $time, got, exp);
        end
    endtask : compare

    task automatic check_pins(input logic [7:0] exp);
        compare("pins", {sel_n, mot_n, soft_reset_n, dma_irq_gate}, exp);
    endtask : check_pins

    task automatic check_side(input logic [7:0] exp);
        compare("side", {4'h0, dma_req, irq, core_dma_ack_n, status_drive_sel}, exp);
    endtask : check_side

    task automatic check_read(input logic [7:0] got, input logic [7:0] exp);
        compare("read", got, exp);
    endtask : check_read

    // ------------------------------------------------------------
    // Host bus cycles
    // ------------------------------------------------------------
    task automatic host_write(input logic [2:0] a, input logic [7:0] d, input logic cs = 0);
        @(posedge clock);
        cs_n <= cs;
        addr <= a;
        data_in <= d;
        wr_n <= 1'b0;
        @(posedge clock);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        @(negedge clock);
    endtask : host_write

    task automatic host_read(input logic [2:0] a, output logic [7:0] d, output logic o);
        @(posedge clock);
        cs_n <= 1'b0;
        addr <= a;
        rd_n <= 1'b0;
        @(negedge clock);
        d = data_out;
        o = data_oe_n;
        @(posedge clock);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        @(negedge clock);
    endtask : host_read

    task automatic test_done;
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    initial begin
        #50000;
        err_count++;
        test_done();
    end

    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        check_pins(exp_pins(8'h00, 1'b0));
        check_side(exp_side(8'h00, 1'b0));
        for (int m = 0; m < 2; m++) begin
            @(posedge clock);
            enhanced_mode <= m[0];
            for (int i = 0; i < 65; i++) begin
                r = (i == 64) ? 8'hFF : 8'(i * 37);
                host_write(FDR_DRIVE_CTRL_ADDR, r);
                check_pins(exp_pins(r, m[0]));
                check_side(exp_side(r, m[0]));
            end
        end
        // Writes elsewhere or without chip select must leave the register alone.
        host_write(FDR_DRIVE_INPUT_ADDR, 8'h00);
        check_pins(exp_pins(8'hFF, 1'b1));
        host_write(FDR_DRIVE_CTRL_ADDR, 8'h00, 1'b1);
        check_pins(exp_pins(8'hFF, 1'b1));
        host_read(FDR_DRIVE_CTRL_ADDR, rd_val, oe);
        check_read({7'h00, oe}, 8'h01);
        host_write(FDR_DRIVE_CTRL_ADDR, 8'h25);
        @(posedge clock);
        media_change <= 3'b010;
        media_hd <= 1'b1;
        host_read(FDR_DRIVE_INPUT_ADDR, rd_val, oe);
        check_read(rd_val, 8'hFE);
        check_read({7'h00, oe}, 8'h00);
        @(posedge clock);
        media_change <= 3'b001;
        media_hd <= 1'b0;
        host_read(FDR_DRIVE_INPUT_ADDR, rd_val, oe);
        check_read(rd_val, 8'h7F);
        @(posedge clock);
        enhanced_mode <= 1'b0;
        media_change <= 3'b010;
        host_read(FDR_DRIVE_INPUT_ADDR, rd_val, oe);
        check_read(rd_val, 8'h80);
        // Vary the core DMA request and the acknowledge so the gate must pass them through.
        host_write(FDR_DRIVE_CTRL_ADDR, 8'h2D);
        check_pins(exp_pins(8'h2D, 1'b0));
        @(posedge clock);
        core_dma_req <= 1'b0;
        dma_ack_n <= 1'b1;
        @(negedge clock);
        check_side(8'h06);
        @(posedge clock);
        enhanced_mode <= 1'b1;
        @(negedge clock);
        check_side(8'h07);
        test_done();
    end
endmodule : tb_top
